//--- design/msc_params.svh
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_ADDR_FIXED 4'ha
`define MSC_UPD_POS 1
`define MSC_RSTN_POS 0
`define MSC_RB_SW_LSB 6
`define MSC_RB_OUT_POS 3
`define MSC_SW_RESET 10'h000
`define MSC_OUT_RESET 1'b0
`define MSC_CMD_BANK_A 7'h00
`define MSC_CMD_BANK_B 7'h01
`define MSC_CMD_SW_FIRST 7'h02
`define MSC_CMD_SW_LAST 7'h0b
`define MSC_CMD_MUX_LO 7'h0e
`define MSC_CMD_MUX_HI 7'h12
`define MSC_CMD_OUT 7'h14
`define MSC_CMD_ALL_OFF 8'h1f
`endif

//--- design/msc_pkg.sv
package msc_pkg;
  typedef logic [9:0] msc_sw_t;
  typedef logic [15:0] msc_word_t;
  typedef enum logic [2:0] {
    MSC_IDLE = 3'b000,
    MSC_ADDR = 3'b001,
    MSC_WDAT = 3'b011,
    MSC_RDAT = 3'b010,
    MSC_SKIP = 3'b110
  } msc_state_e;
endpackage

//--- design/msc_sync.sv
// two-flop synchroniser
module msc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule

//--- design/msc_ctrl.sv
`include "msc_params.svh"
module msc_ctrl #(
  parameter int UPD_POS = `MSC_UPD_POS,
  parameter int RSTN_POS = `MSC_RSTN_POS,
  parameter bit HAS_OUT = 1'b1
) (
  input wire logic mclk, // system clock
  input wire logic rst, // reset, synchronous on mclk, asynchronous for the scl-side wr_tgl_r and drv_r flops; also power-up
  input wire logic scl, // link clock
  input wire logic sda_in, // data line level
  output logic sda_out, // data line drive value (always 0)
  output logic sda_oe_n, // low while pulling data low
  input wire logic addr_select_hi, // address pin
  input wire logic addr_select_mid, // address pin
  input wire logic addr_select_lo, // address pin
  output msc_pkg::msc_sw_t switch_on, // ch1a,ch1b..ch5a,ch5b closed
  output logic general_output // general output pin
);
  import msc_pkg::*;

  // refuse control bit positions the decoder cannot serve
  if (UPD_POS == RSTN_POS || UPD_POS > 7 || RSTN_POS > 7 || UPD_POS < 0 || RSTN_POS < 0) begin : g_bad_pos
    $error("bad control bit positions");
  end

  // link side: sda sampled on rising scl; start is sda falling while scl is high
  // stops are not decoded: every frame opens with a start, which reinitialises the engine
  logic start_r;
  logic start_clr_r;
  logic [2:0] sel_l;

  msc_sync #(.W(3)) u_sel (
    .clk(scl),
    .d({addr_select_hi, addr_select_mid, addr_select_lo}),
    .q(sel_l)
  );

  // start flag, cleared once the first rising scl of the frame has seen it
  always_ff @(negedge sda_in or posedge start_clr_r) begin
    if (start_clr_r) begin
      start_r <= 1'b0;
    end else if (scl) begin
      start_r <= 1'b1;
    end
  end

  always_ff @(posedge scl) begin
    start_clr_r <= start_r;
  end

  msc_state_e st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic byte_cnt_r;
  logic ack_r;
  logic drv_r;
  logic [15:0] rb_l;
  logic [15:0] rb_snap_r;
  logic [15:0] wr_word_r;
  logic wr_tgl_r;
  logic word_done;

  assign word_done = !start_r && st_r == MSC_WDAT && bit_cnt_r == 4'h7 && byte_cnt_r;

  // frame bit engine on rising scl edges
  always_ff @(posedge scl) begin
    if (start_r) begin
      st_r <= MSC_ADDR;
      bit_cnt_r <= 4'h1;
      shift_r <= {7'h00, sda_in};
      byte_cnt_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (bit_cnt_r == 4'h8) begin
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
      if (st_r == MSC_RDAT && sda_in) begin
        st_r <= MSC_SKIP;
      end
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], sda_in};
      if (bit_cnt_r == 4'h7) begin
        unique case (st_r)
          MSC_ADDR: begin
            if (shift_r[6:0] == {`MSC_ADDR_FIXED, sel_l}) begin
              ack_r <= 1'b1;
              // one coherent readback word per read frame
              rb_snap_r <= rb_l;
              st_r <= sda_in ? MSC_RDAT : MSC_WDAT;
            end else begin
              st_r <= MSC_SKIP;
            end
          end
          MSC_WDAT: begin
            ack_r <= 1'b1;
            if (!byte_cnt_r) begin
              cmd_r <= {shift_r[6:0], sda_in};
              byte_cnt_r <= 1'b1;
            end else begin
              wr_word_r <= {cmd_r, shift_r[6:0], sda_in};
              byte_cnt_r <= 1'b0;
            end
          end
          MSC_RDAT: begin
            byte_cnt_r <= ~byte_cnt_r;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // completed word toggles a level that the mclk side watches
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      wr_tgl_r <= 1'b0;
    end else if (word_done) begin
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // drive on falling scl: acknowledge or readback bit
  // reset only lets go of the line; no frame runs while rst is high
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      drv_r <= 1'b0;
    end else if (start_r) begin
      drv_r <= 1'b0;
    // acknowledge the addressed read or write
    end else if (ack_r) begin
      drv_r <= 1'b1;
    // readback bits msb first; master owns the ack slot
    end else if (st_r == MSC_RDAT && bit_cnt_r != 4'h8) begin
      drv_r <= ~rb_snap_r[{~byte_cnt_r, ~bit_cnt_r[2:0]}];
    end else begin
      drv_r <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_r;

  // applied state crosses to scl as a level
  logic [15:0] rb_m;
  msc_sync #(.W(16)) u_rb (
    .clk(scl),
    .d(rb_m),
    .q(rb_l)
  );

  // mclk side
  logic tgl_q;
  logic [1:0] tgl_d_r;
  logic [15:0] word_r;
  logic new_w;
  msc_sync #(.W(1)) u_tgl (
    .clk(mclk),
    .d(wr_tgl_r),
    .q(tgl_q)
  );
  always_ff @(posedge mclk) begin
    if (rst) begin
      tgl_d_r <= 2'b00;
    end else begin
      tgl_d_r <= {tgl_d_r[0], tgl_q};
    end
  end
  assign new_w = tgl_d_r[1] ^ tgl_d_r[0];
  // word is stable long before its toggle is seen
  always_ff @(posedge mclk) begin
    word_r <= wr_word_r;
  end

  logic [9:0] stg_sw_r, stg_mask_r;
  logic stg_out_r, stg_out_v_r;
  logic [9:0] set_m, clr_m;
  logic out_v, out_val;
  logic [6:0] sel;
  logic on;

  always_comb begin
    set_m = 10'h000;
    clr_m = 10'h000;
    out_v = 1'b0;
    out_val = 1'b0;
    sel = word_r[14:8];
    on = word_r[15];
    if (sel == `MSC_CMD_BANK_A || sel == `MSC_CMD_BANK_B) begin
      for (int i = 0; i < 5; i++) begin
        if (on) set_m[9-2*i-int'(sel[0])] = 1'b1;
        else clr_m[9-2*i-int'(sel[0])] = 1'b1;
      end
    end else if (sel >= `MSC_CMD_SW_FIRST && sel <= `MSC_CMD_SW_LAST) begin
      if (on) set_m[9-int'(sel-`MSC_CMD_SW_FIRST)] = 1'b1;
      else clr_m[9-int'(sel-`MSC_CMD_SW_FIRST)] = 1'b1;
    end else if (sel >= `MSC_CMD_MUX_LO && sel <= `MSC_CMD_MUX_HI) begin
      clr_m[9-2*int'(sel-`MSC_CMD_MUX_LO) -: 2] = 2'b11;
    end else if (word_r[15:8] == `MSC_CMD_ALL_OFF) begin
      clr_m = 10'h3ff;
    end else if (sel == `MSC_CMD_OUT && HAS_OUT) begin
      out_v = 1'b1;
      out_val = on;
    end
  end

  // later command per element overwrites staged value
  // staging kept apart from applied state
  always_ff @(posedge mclk) begin
    if (rst || (new_w && (word_r[UPD_POS] || !word_r[RSTN_POS]))) begin
      stg_mask_r <= 10'h000;
      stg_out_v_r <= 1'b0;
      stg_sw_r <= 10'h000;
      stg_out_r <= 1'b0;
    end else if (new_w) begin
      stg_mask_r <= stg_mask_r | set_m | clr_m;
      stg_sw_r <= (stg_sw_r & ~clr_m) | set_m;
      stg_out_v_r <= stg_out_v_r | out_v;
      if (out_v) stg_out_r <= out_val;
    end
  end

  // reset or soft reset clears all; update applies together
  always_ff @(posedge mclk) begin
    if (rst || (new_w && !word_r[RSTN_POS])) begin
      switch_on <= `MSC_SW_RESET;
      general_output <= `MSC_OUT_RESET;
    end else if (new_w && word_r[UPD_POS]) begin
      switch_on <= (switch_on & ~(stg_mask_r | set_m | clr_m)) |
                   (((stg_sw_r & ~clr_m) | set_m) & (stg_mask_r | set_m | clr_m));
      if (out_v) general_output <= out_val;
      else if (stg_out_v_r) general_output <= stg_out_r;
    end
  end

  always_comb begin
    rb_m = 16'h0000;
    rb_m[15:`MSC_RB_SW_LSB] = switch_on;
    rb_m[`MSC_RB_OUT_POS] = HAS_OUT & general_output;
  end
endmodule

//--- verif/msc_ctrl_assertions.sv
module msc_ctrl_checker (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic scl, // link clock
  input wire logic sda_out, // drive value
  input wire logic sda_oe_n, // drive enable
  input wire msc_pkg::msc_sw_t switch_on, // switches
  input wire logic general_output // output pin
);
  import msc_pkg::*;
  logic scl_r;
  logic [3:0] gap_r;
  logic [4:0] low_r;
  always_ff @(posedge mclk) scl_r <= scl;
  // cycles since the last rising link clock
  always_ff @(posedge mclk) begin
    if (rst) gap_r <= 4'hf;
    else if (scl && !scl_r) gap_r <= 4'h0;
    else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst || sda_oe_n) low_r <= 5'h00;
    else if (low_r != 5'h1f) low_r <= low_r + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> switch_on == 10'h000 && !general_output; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("drive value");
  property p_ack; $fell(sda_oe_n) |-> !scl; endproperty
  a_ack: assert property (p_ack) else $error("drive edge");
  property p_rel; $rose(sda_oe_n) |-> !scl; endproperty
  a_rel: assert property (p_rel) else $error("release edge");
  property p_run; low_r < 5'h1c; endproperty
  a_run: assert property (p_run) else $error("low run");
  property p_idle; gap_r == 4'hf |-> sda_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_tog; !$stable({switch_on, general_output}) |=> $stable({switch_on, general_output}) [*8]; endproperty
  a_tog: assert property (p_tog) else $error("split update");
  property p_app; !$stable({switch_on, general_output}) |-> gap_r <= 4'h6; endproperty
  a_app: assert property (p_app) else $error("late update");
endmodule
bind msc_ctrl msc_ctrl_checker chk_u (.mclk(mclk), .rst(rst), .scl(scl), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .switch_on(switch_on), .general_output(general_output));

//--- verif/msc_i2c_master.sv
`include "msc_params.svh"
module msc_i2c_master (
  output logic scl, // idle high
  output logic drv_low, // pulls data low
  input wire logic sda // line level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic r;
  logic ack;
  logic [7:0] rx;
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end
  // data moves only while the clock is low
  task automatic bit_io(input logic b);
    #8 drv_low = ~b;
    #24 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i]);
      rx[i] = r;
    end
    bit_io(last);
    ack = ~r;
  endtask
  task automatic start;
    #16 drv_low = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic stop;
    #8 drv_low = 1'b1;
    #24 scl = 1'b1;
    #16 drv_low = 1'b0;
    #32;
  endtask
  task automatic write_word(input logic [2:0] sel, input logic [7:0] cmd, input logic [7:0] c, output logic ok);
    start();
    xbyte({`MSC_ADDR_FIXED, sel, 1'b0}, 1'b1);
    ok = ack;
    xbyte(cmd, 1'b1);
    xbyte(c, 1'b1);
    stop();
  endtask
  // ack first byte, refuse the second
  task automatic read_word(input logic [2:0] sel, output logic [15:0] w, output logic ok);
    start();
    xbyte({`MSC_ADDR_FIXED, sel, 1'b1}, 1'b1);
    ok = ack;
    xbyte(8'hff, 1'b0);
    w[15:8] = rx;
    xbyte(8'hff, 1'b1);
    w[7:0] = rx;
    stop();
  endtask
endmodule

//--- verif/test_i2c_mux_switch_control.sv
`include "msc_params.svh"
module test_i2c_mux_switch_control;
  timeunit 1ns;
  timeprecision 100ps;
  import msc_pkg::*;
  logic mclk = 1'b0;
  logic rst;
  logic [2:0] pins = 3'b101;
  logic scl, drv_low, sda_out, sda_oe_n, gen_out, ok;
  msc_sw_t sw;
  logic [15:0] rb;
  int err_count = 0, comparisons = 0, cyc = 0;
  wire logic sda = ~drv_low & (sda_oe_n | sda_out);
  logic [7:0] cmds [17] = '{8'h82, 8'h80, 8'h0e, 8'h0f, 8'h00, 8'h81, 8'h10, 8'h11, 8'h12,
    8'h8b, 8'h01, 8'h0c, 8'h94, 8'h87, 8'h9f, 8'h1f, 8'h14};
  logic [10:0] exps [17] = '{11'h200, 11'h2aa, 11'h0aa, 11'h02a, 11'h000, 11'h155, 11'h145, 11'h141,
    11'h140, 11'h141, 11'h000, 11'h000, 11'h400, 11'h410, 11'h410, 11'h400, 11'h000};
  msc_ctrl dut_u (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_hi(pins[2]), .addr_select_mid(pins[1]), .addr_select_lo(pins[0]), .switch_on(sw),
    .general_output(gen_out));
  msc_i2c_master mst_u (.scl(scl), .drv_low(drv_low), .sda(sda));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // control byte from update and soft-reset bits
  function automatic logic [7:0] ctl(input logic upd, input logic rstn);
    return (8'(upd) << `MSC_UPD_POS) | (8'(rstn) << `MSC_RSTN_POS);
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] cmd, input logic [7:0] c, input logic a);
    mst_u.write_word(sel, cmd, c, ok);
    chk("ack", {15'h0000, a}, {15'h0000, ok});
    repeat (8) @(posedge mclk);
  endtask
  task automatic st(input logic [10:0] e);
    chk("state", {5'h00, e}, {5'h00, gen_out, sw});
    mst_u.read_word(3'b101, rb, ok);
    chk("read ack", 16'h0001, {15'h0000, ok});
    chk("readback", {e[9:0], 2'b00, e[10], 3'b000}, rb);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    st(11'h000);
    wr(3'b111, 8'h82, ctl(1'b1, 1'b1), 1'b0);
    st(11'h000);
    for (int i = 0; i < 17; i++) begin
      wr(3'b101, cmds[i], ctl(1'b1, 1'b1), 1'b1);
      st(exps[i]);
    end
    wr(3'b101, 8'h82, ctl(1'b0, 1'b1), 1'b1);
    st(11'h000);
    wr(3'b101, 8'h85, ctl(1'b0, 1'b1), 1'b1);
    wr(3'b101, 8'h05, ctl(1'b1, 1'b1), 1'b1);
    st(11'h200);
    wr(3'b101, 8'h8b, ctl(1'b1, 1'b0), 1'b1);
    st(11'h000);
    test_done();
  end
endmodule
